// ### logic/pma_pkg.sv
// shared constants and types for the phy management access port
package pma_pkg;
	// register byte addresses
	localparam logic [31:0] CMD_ADDR  = 32'h8001_0010;
	localparam logic [31:0] DATA_ADDR = 32'h8001_0014;
	localparam logic [31:0] STS_ADDR  = 32'h8001_0018;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// field positions
	localparam int OP_HI    = 15;
	localparam int OP_LO    = 14;
	localparam int DEV_HI   = 9;
	localparam int DEV_LO   = 5;
	localparam int REG_HI   = 4;
	localparam int REG_LO   = 0;
	localparam int BUSY_BIT = 0;
	localparam int DATA_W   = 16;
	// operation codes
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	// serial frame layout, bit index counts from the first preamble bit
	localparam logic [31:0] PREAMBLE   = 32'hFFFF_FFFF;
	localparam logic [1:0]  START_PAT  = 2'h1;
	localparam logic [1:0]  TA_WRITE   = 2'h2;
	localparam logic [1:0]  TA_READ    = 2'h3;
	localparam logic [5:0]  RD_RELEASE = 6'h2E;
	localparam logic [5:0]  RD_FIRST   = 6'h30;
	localparam logic [5:0]  LAST_BIT   = 6'h3F;
	// management clock timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int MDC_HALF_NS   = 200;
	localparam int MDC_HALF_CYC  = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// command register contents
	typedef struct packed {
		logic [1:0] operation_code;
		logic [4:0] target_device_select;
		logic [4:0] target_register_select;
	} pma_cmd_t;
	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_SHIFT = 1'b1
	} pma_state_t;
endpackage

// ### logic/pma_top.sv
// apb register front end and serial management engine for external phys
`timescale 1ns/10ps
module pma_top import pma_pkg::*; #(
	parameter logic [7:0] DIV = 8'(MDC_HALF_CYC)
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// management pins
	output logic             mdc,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe
);
	pma_state_t  state_q, state_d;
	pma_cmd_t    cmd_q, cmd_d;
	logic [15:0] data_q, data_d;
	logic        busy_q, busy_d;
	logic [63:0] frame_q, frame_d;
	logic [5:0]  bit_q, bit_d;
	logic [7:0]  div_q, div_d;
	logic [15:0] rd_q, rd_d;
	logic        rd_op_q, rd_op_d;
	logic        mdc_q, mdc_d;
	logic        out_q, out_d;
	logic        oe_q, oe_d;
	logic        sync1_q, sync1_d;
	logic        sync2_q, sync2_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic        commit;
	logic        mapped;
	logic        cmd_wr;
	logic        pend_q, pend_d;
	logic [15:0] len_q, len_d;
	// cycles a frame keeps the engine busy: 64 bits, two mdc halves of DIV cycles each
	localparam logic [15:0] FRAME_CYC = 16'(DIV) * 16'h0080;

	// a transfer takes effect at the edge where the master sees pready
	assign commit = psel & penable & pready_q;
	assign mapped = (paddr == CMD_ADDR) || (paddr == DATA_ADDR) || (paddr == STS_ADDR);
	assign cmd_wr = commit & pwrite & (paddr == CMD_ADDR);

	// next state for bus front end and serial engine
	always_comb begin
		state_d   = state_q;
		cmd_d     = cmd_q;
		data_d    = data_q;
		busy_d    = busy_q;
		frame_d   = frame_q;
		bit_d     = bit_q;
		div_d     = div_q;
		rd_d      = rd_q;
		rd_op_d   = rd_op_q;
		mdc_d     = mdc_q;
		out_d     = out_q;
		oe_d      = oe_q;
		pend_d    = pend_q;
		sync1_d   = mdio_in;
		sync2_d   = sync1_q;
		pready_d  = psel & penable & ~pready_q;
		prdata_d  = REG_RESET;
		pslverr_d = 1'b0;
		// one wait state: read data and error are prepared before pready rises
		if (psel && penable && !pready_q) begin
			if (paddr == CMD_ADDR) begin
				prdata_d[OP_HI:OP_LO]   = cmd_q.operation_code;
				prdata_d[DEV_HI:DEV_LO] = cmd_q.target_device_select;
				prdata_d[REG_HI:REG_LO] = cmd_q.target_register_select;
			end else if (paddr == DATA_ADDR) begin
				prdata_d[DATA_W-1:0] = data_q;
			end else if (paddr == STS_ADDR) begin
				prdata_d[BUSY_BIT] = busy_q;
			end else begin
				pslverr_d = 1'b1;
			end
		end
		// register writes; reserved bits are dropped and read back as zero
		if (commit && pwrite) begin
			if (paddr == CMD_ADDR) begin
				cmd_d.operation_code         = pwdata[OP_HI:OP_LO];
				cmd_d.target_device_select   = pwdata[DEV_HI:DEV_LO];
				cmd_d.target_register_select = pwdata[REG_HI:REG_LO];
			end else if (paddr == DATA_ADDR) begin
				data_d = pwdata[DATA_W-1:0];
			end
		end
		// serial engine; drives on the falling mdc edge, samples on the rising one
		case (state_q)
			ST_IDLE: begin
				mdc_d = 1'b0;
				div_d = 8'h00;
				oe_d  = 1'b0;
				pend_d = 1'b0;
				if (busy_q) begin
					if (cmd_q.operation_code == OP_READ || cmd_q.operation_code == OP_WRITE) begin
						state_d = ST_SHIFT;
						rd_op_d = (cmd_q.operation_code == OP_READ);
						frame_d = {PREAMBLE, START_PAT, cmd_q.operation_code,
							cmd_q.target_device_select, cmd_q.target_register_select,
							(cmd_q.operation_code == OP_READ) ? TA_READ : TA_WRITE, data_q};
						bit_d   = 6'h00;
						out_d   = 1'b1;
						oe_d    = 1'b1;
						pend_d  = cmd_wr; // a command landing at launch runs next
					end else begin
						busy_d = 1'b0; // undefined opcode: nothing to do
					end
				end
			end
			ST_SHIFT: begin
				// a command that lands mid-frame is queued and runs once this frame ends
				pend_d = pend_q | cmd_wr;
				if (div_q == DIV - 8'h01) begin
					div_d = 8'h00;
					mdc_d = ~mdc_q;
					if (!mdc_q) begin
						// rising edge: phy samples our bit, or we take its bit
						if (rd_op_q && bit_q >= RD_FIRST) begin
							rd_d = {rd_q[14:0], sync2_q};
						end
					end else if (bit_q == LAST_BIT) begin
						// falling edge after the last bit: the phy has it
						state_d = ST_IDLE;
						busy_d  = pend_q; // a queued command keeps busy up
						oe_d    = 1'b0;
						if (rd_op_q) begin
							data_d = rd_q;
						end
					end else begin
						bit_d   = bit_q + 6'h01;
						frame_d = {frame_q[62:0], 1'b0};
						out_d   = frame_q[62];
						oe_d    = !(rd_op_q && bit_q >= RD_RELEASE - 6'h01);
					end
				end else begin
					div_d = div_q + 8'h01;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		// a command write always marks busy, even on top of a finishing frame
		if (commit && pwrite && paddr == CMD_ADDR) begin
			busy_d = 1'b1;
		end
	end

	// register all state
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q   <= ST_IDLE;
			cmd_q     <= '0;
			data_q    <= REG_RESET[DATA_W-1:0];
			busy_q    <= 1'b0;
			frame_q   <= 64'h0000_0000_0000_0000;
			bit_q     <= 6'h00;
			div_q     <= 8'h00;
			rd_q      <= 16'h0000;
			rd_op_q   <= 1'b0;
			mdc_q     <= 1'b0;
			out_q     <= 1'b0;
			oe_q      <= 1'b0;
			pend_q    <= 1'b0;
			sync1_q   <= 1'b0;
			sync2_q   <= 1'b0;
			prdata_q  <= REG_RESET;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			cmd_q     <= cmd_d;
			data_q    <= data_d;
			busy_q    <= busy_d;
			frame_q   <= frame_d;
			bit_q     <= bit_d;
			div_q     <= div_d;
			rd_q      <= rd_d;
			rd_op_q   <= rd_op_d;
			mdc_q     <= mdc_d;
			out_q     <= out_d;
			oe_q      <= oe_d;
			pend_q    <= pend_d;
			sync1_q   <= sync1_d;
			sync2_q   <= sync2_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// frame length tracker, read only by the checks below
	always_comb begin
		len_d = (state_q == ST_SHIFT) ? len_q + 16'h0001 : 16'h0000;
	end

	// cleared in idle so each frame counts from zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			len_q <= 16'h0000;
		end else begin
			len_q <= len_d;
		end
	end

	// outputs straight from flops
	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign mdc      = mdc_q;
	assign mdio_out = out_q;
	assign mdio_oe  = oe_q;

	// checks on the engine and register file
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_busy_on_cmd: assert property (commit && pwrite && paddr == CMD_ADDR |=> busy_q)
		else $error("busy not set after command write");
	a_busy_shift: assert property (state_q == ST_SHIFT |-> busy_q)
		else $error("busy dropped while frame in flight");
	a_done_last: assert property ($fell(state_q == ST_SHIFT) |-> $past(bit_q) == LAST_BIT && !mdc_q
		&& busy_q == ($past(pend_q) || $past(cmd_wr)))
		else $error("frame ended early");
	a_read_load: assert property ($fell(state_q == ST_SHIFT) && rd_op_q |-> data_q == $past(rd_q))
		else $error("read word not loaded");
	a_op_start: assert property (state_q == ST_IDLE && busy_q && (cmd_q.operation_code == OP_READ
		|| cmd_q.operation_code == OP_WRITE) |=> state_q == ST_SHIFT ##0 rd_op_q == ($past(cmd_q.operation_code) == OP_READ))
		else $error("opcode not decoded");
	a_rd_release: assert property (state_q == ST_SHIFT && rd_op_q && bit_q >= RD_RELEASE |-> !mdio_oe)
		else $error("read turnaround still driven");
	a_dev_field: assert property ($rose(state_q == ST_SHIFT) |-> frame_q[27:23] == $past(cmd_q.target_device_select))
		else $error("wrong device in frame");
	a_reg_field: assert property ($rose(state_q == ST_SHIFT) |-> frame_q[22:18] == $past(cmd_q.target_register_select))
		else $error("wrong register in frame");
	a_data_width: assert property (pready_q && paddr == DATA_ADDR |-> prdata_q[31:16] == 16'h0000)
		else $error("data upper half not zero");
	a_status_read: assert property (psel && penable && !pready_q && paddr == STS_ADDR
		|=> prdata_q[BUSY_BIT] == $past(busy_q))
		else $error("status busy bit wrong");
	a_unmapped_err: assert property (psel && penable && !pready_q && !mapped |=> pslverr_q)
		else $error("unmapped access not flagged");
	// bus side: one-cycle answers, no error on mapped words, reserved bits quiet
	a_pready_pulse: assert property (pready_q |=> !pready_q)
		else $error("pready held longer than one cycle");
	a_err_mapped: assert property (pready_q && mapped |-> !pslverr_q)
		else $error("error on a mapped register");
	a_status_upper: assert property (pready_q && paddr == STS_ADDR |-> prdata_q[31:1] == 31'h0000_0000)
		else $error("status reserved bits not zero");
	a_cmd_upper: assert property (pready_q && paddr == CMD_ADDR
		|-> prdata_q[31:16] == 16'h0000 && prdata_q[13:10] == 4'h0)
		else $error("command reserved bits not zero");
	// register file: writes land in the addressed word
	a_cmd_store: assert property (cmd_wr |=> cmd_q.operation_code == $past(pwdata[OP_HI:OP_LO])
		&& cmd_q.target_device_select == $past(pwdata[DEV_HI:DEV_LO])
		&& cmd_q.target_register_select == $past(pwdata[REG_HI:REG_LO]))
		else $error("command word not stored");
	a_data_store: assert property (commit && pwrite && paddr == DATA_ADDR && state_q == ST_IDLE
		|=> data_q == $past(pwdata[DATA_W-1:0]))
		else $error("data word not stored");
	// engine: quiet when idle, drives the whole write frame, drops reserved opcodes
	a_idle_quiet: assert property (state_q == ST_IDLE |-> !mdc_q && !mdio_oe)
		else $error("management pins active while idle");
	a_frame_start: assert property ($rose(state_q == ST_SHIFT)
		|-> mdio_oe && mdio_out && !mdc_q && bit_q == 6'h00)
		else $error("frame did not start on the first preamble bit");
	a_write_drive: assert property (state_q == ST_SHIFT && !rd_op_q |-> mdio_oe)
		else $error("write frame not driven");
	a_badop_clear: assert property (state_q == ST_IDLE && busy_q && cmd_q.operation_code != OP_READ
		&& cmd_q.operation_code != OP_WRITE && !cmd_wr |=> state_q == ST_IDLE && !busy_q)
		else $error("reserved opcode not dropped");
	// frame timing, counted by div_q and by the length tracker
	a_mdc_steady: assert property (state_q == ST_SHIFT && div_q != DIV - 8'h01 |=> $stable(mdc_q))
		else $error("mdc moved before its half period ended");
	a_frame_len: assert property ($fell(state_q == ST_SHIFT) |-> $past(len_q) == FRAME_CYC - 16'h0001)
		else $error("frame length wrong");

	c_read_done: cover property ($fell(state_q == ST_SHIFT) && rd_op_q);
	c_write_done: cover property ($fell(state_q == ST_SHIFT) && !rd_op_q);
	c_unmapped: cover property (pready_q && pslverr_q);
	c_queued_cmd: cover property (state_q == ST_SHIFT && cmd_wr);
	c_bad_opcode: cover property (state_q == ST_IDLE && busy_q && cmd_q.operation_code != OP_READ
		&& cmd_q.operation_code != OP_WRITE);
endmodule

// ### verification/pma_phy_model.sv
// behavioural model of the external phy management registers
`timescale 1ns/10ps
module pma_phy_model (
	// shared management line as the phy sees it
	input  wire logic mdc,
	input  wire logic mdio,
	input  wire logic mdio_oe,
	// phy drive back onto the line
	output logic      phy_oe,
	output logic      phy_out
);
	logic [15:0] mem [0:1023];
	logic [63:0] sh;
	logic [11:0] hdr;
	logic        act;
	int          cnt;
	int          nframes;
	// each register starts from its own index, so a wrong select shows up
	initial begin
		for (int i = 0; i < 1024; i++) mem[i] = 16'(i) ^ 16'h5A00;
		act = 1'b0;
		cnt = 0;
		nframes = 0;
		phy_oe = 1'b0;
		phy_out = 1'b0;
	end
	// a frame begins when the host takes the line
	always @(posedge mdio_oe) if (!act) begin
		act = 1'b1;
		cnt = 0;
	end
	// sample on rising mdc; header known after bit 45, writes land after bit 63
	always @(posedge mdc) if (act) begin
		sh = {sh[62:0], mdio};
		cnt = cnt + 1;
		if (cnt == 46) hdr = sh[11:0];
		if (cnt == 64) begin
			act = 1'b0;
			nframes++;
			if (sh[29:28] == 2'h1) mem[sh[27:18]] = sh[15:0];
		end
	end
	// read turnaround low, then data msb first; changes on falling mdc to give setup time
	always @(negedge mdc) begin
		if (act && cnt >= 47 && hdr[11:10] == 2'h2) begin
			phy_oe <= 1'b1;
			phy_out <= (cnt == 47) ? 1'b0 : mem[hdr[9:0]][63 - cnt];
		end else begin
			phy_oe <= 1'b0;
		end
	end
endmodule

// ### verification/pma_top_tb.sv
// self-checking bench for the phy management access port
`timescale 1ns/10ps
module pma_top_tb;
	import pma_pkg::*;
	logic        ref_clk = 1'b0;
	logic        srst    = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] paddr   = 32'h0;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, mdc, mdio_out, mdio_oe, phy_oe, phy_out, er;
	wire logic   mdio_line;
	int          err_count = 0;
	int          n_checks  = 0;
	// pull-up holds the line high when nobody drives it
	assign mdio_line = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);
	pma_top #(.DIV(8'h04)) i_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
	pma_phy_model i_phy (.mdc(mdc), .mdio(mdio_line), .mdio_oe(mdio_oe), .phy_oe(phy_oe), .phy_out(phy_out));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task summarize;
		if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			err_count++;
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 50) begin
			err_count++;
			summarize;
		end
	endtask
	task wait_idle;
		int i;
		for (i = 0; i < 400; i++) begin
			apb(1'b0, STS_ADDR, 32'h0);
			if (rd[BUSY_BIT] === 1'b0) break;
		end
		if (i == 400) begin
			err_count++;
			summarize;
		end
	endtask
	task phy_wr(input logic [4:0] dv, input logic [4:0] rg, input logic [31:0] d);
		apb(1'b1, DATA_ADDR, d);
		apb(1'b1, CMD_ADDR, 32'({OP_WRITE, 4'h0, dv, rg}));
		apb(1'b0, STS_ADDR, 32'h0);
		check(rd, 32'h1);
		wait_idle;
		check(32'(i_phy.mem[{dv, rg}]), 32'(d[15:0]));
	endtask
	task phy_rd(input logic [4:0] dv, input logic [4:0] rg, input logic [15:0] exp);
		apb(1'b1, CMD_ADDR, 32'({OP_READ, 4'h0, dv, rg}));
		wait_idle;
		apb(1'b0, DATA_ADDR, 32'h0);
		check(32'(rd[15:0]), 32'(exp));
	endtask
	task t_reset;
		check(32'({mdc, mdio_oe}), 32'h0);
		apb(1'b0, CMD_ADDR, 32'h0);
		check(rd, REG_RESET);
		apb(1'b0, DATA_ADDR, 32'h0);
		check(rd, REG_RESET);
		apb(1'b0, STS_ADDR, 32'h0);
		check(rd, REG_RESET);
	endtask
	task t_bus;
		apb(1'b1, 32'h8001_001C, 32'hFFFF_FFFF);
		check(32'(er), 32'h1);
		apb(1'b1, STS_ADDR, 32'h1);
		apb(1'b0, STS_ADDR, 32'h0);
		check(rd, 32'h0);
	endtask
	task t_transfers;
		phy_rd(5'h03, 5'h02, 16'h5A62);
		phy_wr(5'h1F, 5'h1F, 32'h0000_BEEF);
		phy_wr(5'h00, 5'h01, 32'hFFFF_1234);
		phy_rd(5'h1F, 5'h1F, 16'hBEEF);
		phy_rd(5'h00, 5'h01, 16'h1234);
		phy_rd(5'h01, 5'h00, 16'h5A20);
	endtask
	// reserved opcodes finish without a frame and leave the data word alone
	task t_badop;
		int n;
		for (int op = 0; op < 4; op += 3) begin
			n = i_phy.nframes;
			apb(1'b1, CMD_ADDR, 32'({2'(op), 14'h0021}));
			wait_idle;
			check(32'(i_phy.nframes), 32'(n));
			apb(1'b0, DATA_ADDR, 32'h0);
			check(32'(rd[15:0]), 32'h5A20);
		end
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		t_reset;
		t_bus;
		t_transfers;
		t_badop;
		summarize;
	end
endmodule
